// File: hdl/aphp_pkg.sv
// constants for the converter parallel host port
package aphp_pkg;
    // ----------------------------------------------------------------
    // data format
    // ----------------------------------------------------------------
    localparam int RESULT_W = 12;
    localparam int NIB_W    = 4;
    localparam logic [11:0] RESULT_RST = 12'h000;
    localparam logic [3:0]  NIB_ZERO   = 4'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 8;
    localparam int CONV_TIME_NS    = 2700;
    // longest time: rounds down
    localparam int CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int DATA_SETUP_NS   = 90;
    localparam int DATA_SETUP_CYC  = DATA_SETUP_NS / CLK_PERIOD_NS;
    localparam int RD_GAP_NS       = 40;
    // least time: rounds up
    localparam int RD_GAP_CYC      = (RD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQ_NS          = 600;
    localparam int ACQ_CYC         = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_CYCLES      = CONV_CYCLES / RESULT_W;
    localparam int CNT_W           = 9;
    localparam logic [8:0] BIT_LAST = 9'(BIT_CYCLES - 1);
    localparam logic [3:0] BIT_TOP  = 4'(RESULT_W - 1);

    typedef enum logic [0:0] {ST_IDLE, ST_CONV} aphp_state_t;
endpackage : aphp_pkg

// File: hdl/aphp_port.sv
// parallel read and conversion-start port of a 12-bit sampling converter
`timescale 1ns/1ns
// Overview of operation
// RULE_01: read strobe and upper byte select ignored unless chip select low.
// RULE_02: falling read strobe starts conversion when chip select and byte select low.
// RULE_03: read with upper byte select high only reads data, never starts.
// RULE_04: data outputs driven only while chip select and read strobe low.
// RULE_05: busy low throughout a conversion, high otherwise.
// RULE_06: byte select low: lines carry result bits 11 down to 0.
// RULE_07: byte select high: bits 11..8, four zeros, bits 11..8 again.
// RULE_08: host leaves at least 40 ns between read strobe pulses.
// RULE_09: new result valid on outputs within 90 ns after busy rises.
// RULE_10: conversion start clears approximation register and enables outputs.
// RULE_11: start conditions ignored while a conversion is under way.
// RULE_12: host allows 600 ns acquisition between conversions.
// RULE_13: result bit 11 is the most significant bit.
// RULE_14: final word latched before busy rises, held until next conversion ends (here latched on the same edge that busy rises).
module aphp_port (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        read_n_i,
    input  wire logic        upper_byte_select_i,
    input  wire logic        comparator_i,
    output logic             busy_n_o,
    output logic [11:0]      data_o,
    output logic [11:0]      data_oe_o
);
    // no conversion clock of its own: bit slots are counted on clk_sys_i
    // comparator_i stands in for the analog compare, taken once per slot
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    aphp_pkg::aphp_state_t state;
    logic [11:0] approximation_register;
    logic [11:0] result;
    logic [3:0]  bit_idx;
    logic [8:0]  bit_cnt;
    logic        read_n_q;
    logic [8:0]  busy_cycles;
    // expected busy-low length: twelve bit slots, the odd budget cycle dropped
    localparam logic [8:0] CONV_LEN = 9'(aphp_pkg::RESULT_W * aphp_pkg::BIT_CYCLES);

    // ----------------------------------------------------------------
    // byte view of a result word
    // ----------------------------------------------------------------
    // upper nibble repeated on the shared low lines, middle lines low
    function automatic logic [11:0] byte_view(input logic [11:0] word, input logic upper);
        return upper ? {word[11:8], aphp_pkg::NIB_ZERO, word[11:8]} : word;   // RULE_07
    endfunction : byte_view

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire selected   = ~chip_select_n_i;                                // RULE_01
    wire rd_fall    = selected & ~read_n_i & read_n_q;
    wire start_req  = rd_fall & ~upper_byte_select_i;                  // RULE_02 RULE_03
    // a start seen mid conversion is dropped, not queued
    wire start_conv = start_req & (state == aphp_pkg::ST_IDLE);        // RULE_11
    // slot ends after BIT_CYCLES edges; the last budget cycle goes unused
    wire bit_done   = (state == aphp_pkg::ST_CONV) && (bit_cnt == aphp_pkg::BIT_LAST);
    wire last_bit   = bit_done && (bit_idx == 4'h0);
    wire [11:0] trial_mask = 12'h001 << bit_idx;
    // msb decided first, bit 11 is the top weight
    wire [11:0] decided = comparator_i ? approximation_register
                                       : (approximation_register & ~trial_mask); // RULE_13
    wire [11:0] next_sar = bit_idx == 4'h0 ? decided : (decided | (trial_mask >> 1));
    wire [11:0] held_view = byte_view(result, upper_byte_select_i);         // RULE_06 RULE_07
    wire [11:0] done_view = byte_view(decided, upper_byte_select_i);        // RULE_09
    // the word just decided goes out on the edge that ends busy
    wire [11:0] next_data = last_bit ? done_view : held_view;
    wire drive = selected & ~read_n_i;                                       // RULE_04

    // ----------------------------------------------------------------
    // strobe edge history
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            read_n_q <= 1'b1;
        end else begin
            // only tracked while selected so a deselected strobe is no edge
            read_n_q <= read_n_i | chip_select_n_i;
        end
    end

    // ----------------------------------------------------------------
    // successive approximation sequencer
    // ----------------------------------------------------------------
    // trial word starts with only the top bit set, lower bits clear
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state                  <= aphp_pkg::ST_IDLE;
            approximation_register <= 12'h000;
            bit_idx                <= 4'h0;
            bit_cnt                <= 9'h000;
        end else if (start_conv) begin
            state                  <= aphp_pkg::ST_CONV;
            approximation_register <= 12'h800;                         // RULE_10
            bit_idx                <= aphp_pkg::BIT_TOP;
            bit_cnt                <= 9'h000;
        end else if (state == aphp_pkg::ST_CONV) begin
            bit_cnt <= bit_done ? 9'h000 : bit_cnt + 9'h001;
            if (bit_done) begin
                approximation_register <= next_sar;
                bit_idx                <= bit_idx - 4'h1;
                if (last_bit) begin
                    state <= aphp_pkg::ST_IDLE;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // output latch, busy and bus
    // ----------------------------------------------------------------
    // result moves only on the last decision: a read mid conversion sees the old word
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            result <= aphp_pkg::RESULT_RST;
        end else if (last_bit) begin
            result <= decided;                                          // RULE_14
        end
    end

    // busy rises together with the latched word, so data leads busy by zero cycles
    assign busy_n_o = (state != aphp_pkg::ST_CONV);                    // RULE_05 RULE_09
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_o <= 12'h000;
        end else begin
            data_o <= next_data;
        end
    end
    // enable is combinational; data lags a change of byte select by one cycle
    assign data_oe_o = {12{drive}};                                    // RULE_04 RULE_10

    // ----------------------------------------------------------------
    // conversion length watch, read by the checks only
    // ----------------------------------------------------------------
    // counts busy-low cycles so the length check needs no long repetition
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_cycles <= 9'h000;
        end else begin
            busy_cycles <= busy_n_o ? 9'h000 : busy_cycles + 9'h001;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_busy_low_conv: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_05
        start_conv |=> !busy_n_o [*8]) else $error("busy not low during conversion");
    chk_no_start_hbe: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_03
        (busy_n_o && upper_byte_select_i) |=> busy_n_o) else $error("start with byte select high");
    chk_no_start_desel: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_01
        (busy_n_o && chip_select_n_i) |=> busy_n_o) else $error("start while deselected");
    chk_start_on_fall: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_02
        (busy_n_o && start_req) |=> !busy_n_o) else $error("start missed");
    chk_oe_follows: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_04
        data_oe_o == {12{!chip_select_n_i && !read_n_i}}) else $error("bus enable wrong");
    chk_sar_clear: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_10
        start_conv |=> approximation_register == 12'h800) else $error("register not cleared");
    chk_no_restart: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_11
        (!busy_n_o && !last_bit) |=> $stable(bit_idx) || bit_idx == $past(bit_idx) - 4'h1)
        else $error("conversion restarted");
    chk_result_held: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_14
        !last_bit |=> $stable(result)) else $error("result changed mid conversion");
    chk_hi_view: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_07
        (busy_n_o && $past(busy_n_o) && $stable(upper_byte_select_i) && upper_byte_select_i)
        |-> data_o == {result[11:8], 4'h0, result[11:8]}) else $error("byte view wrong");
    chk_data_at_busy: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_09
        $rose(busy_n_o) && !$past(upper_byte_select_i) |-> data_o == result)
        else $error("data late after busy");
    // bus view, latch and strobe history
    chk_full_view: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_06
        (busy_n_o && $past(busy_n_o) && $stable(upper_byte_select_i) && !upper_byte_select_i)
        |-> data_o == result) else $error("full word view wrong");
    chk_latch_first: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_14
        last_bit |=> busy_n_o && result == $past(decided))
        else $error("word not latched as busy rises");
    chk_desel_quiet: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_01
        chip_select_n_i |-> data_oe_o == 12'h000)
        else $error("bus driven while deselected");
    chk_rd_hist: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_01
        chip_select_n_i |=> read_n_q)
        else $error("deselected strobe kept as edge");
    chk_oe_on_start: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_10
        start_conv |-> data_oe_o == 12'hFFF)
        else $error("bus not enabled at start");

    // sequencer
    chk_conv_len: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_05
        $rose(busy_n_o) |-> busy_cycles == CONV_LEN)
        else $error("busy low for wrong number of cycles");
    chk_slot_restart: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_05
        bit_done && !last_bit |=> !busy_n_o && bit_cnt == 9'h000)
        else $error("bit slot did not restart");
    chk_msb_first: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_13
        start_conv |=> bit_idx == aphp_pkg::BIT_TOP)
        else $error("first trial not the top bit");
    chk_bit_decide: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_13
        bit_done |=> approximation_register[$past(bit_idx)] == $past(comparator_i))
        else $error("trial bit not set by comparator");
    chk_idle_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_11
        (busy_n_o && !start_conv) |=> $stable(approximation_register) && $stable(bit_cnt))
        else $error("sequencer moved while idle");
    chk_cnt_range: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE_11
        !busy_n_o |-> bit_cnt <= aphp_pkg::BIT_LAST && bit_idx <= aphp_pkg::BIT_TOP)
        else $error("slot or bit counter out of range");

    // ----------------------------------------------------------------
    // coverage
    // ----------------------------------------------------------------
    cov_conv: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) $rose(busy_n_o));
    cov_hi_read: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        drive && upper_byte_select_i);
    cov_ignored: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        start_req && !busy_n_o);
    cov_full_read: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        drive && !upper_byte_select_i && busy_n_o);
    cov_desel_strobe: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        chip_select_n_i && !read_n_i);
endmodule : aphp_port

// File: testbench/aphp_host.sv
// host bus model issuing one read strobe per request
`timescale 1ns/1ns
module aphp_host (
    input  wire logic clk_sys_i,
    input  wire logic go_i,
    input  wire logic sel_i,
    input  wire logic up_i,
    output logic      cs_n_o,
    output logic      rd_n_o,
    output logic      up_o
);
    logic [3:0] cnt = 4'h0;
    logic       sel = 1'b0;
    logic       up  = 1'b0;
    // strobe low 6 cycles, then 8 quiet cycles for the gap
    assign rd_n_o = (cnt < 4'h9);
    assign cs_n_o = !(sel && cnt != 4'h0);
    assign up_o   = up;
    always @(posedge clk_sys_i) begin
        if (cnt != 4'h0) cnt <= cnt - 4'h1;
        else if (go_i) begin
            cnt <= 4'hE;
            sel <= sel_i;
            up  <= up_i;
        end
    end
endmodule : aphp_host

// File: testbench/aphp_port_tb.sv
// self-checking bench for the converter host port
`timescale 1ns/1ns
module aphp_port_tb;
    logic clk_sys_i = 1'b0, resetn_i = 1'b0, go = 1'b0, sel = 1'b0, up = 1'b0, cmp = 1'b0;
    logic cs_n, rd_n, ub, busy_n;
    logic [11:0] d, oe, w = 12'h000, dq, oq;
    logic [31:0] seed = 32'h9;
    logic [11:0] prev = aphp_pkg::RESULT_RST;
    int num_errors = 0, checked = 0, cnt = 0, len = 0, cyc = 0, idx;
    always #4 clk_sys_i = ~clk_sys_i;
    aphp_host HOST (.clk_sys_i(clk_sys_i), .go_i(go), .sel_i(sel), .up_i(up),
                    .cs_n_o(cs_n), .rd_n_o(rd_n), .up_o(ub));
    aphp_port DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .chip_select_n_i(cs_n),
                   .read_n_i(rd_n), .upper_byte_select_i(ub), .comparator_i(cmp),
                   .busy_n_o(busy_n), .data_o(d), .data_oe_o(oe));
    // comparator changes mid slot so the sampling edge never races it
    assign idx = (cnt < 14) ? 0 : (cnt - 14) / 28;
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
        cmp <= w[11 - ((idx > 11) ? 11 : idx)];
        if (busy_n === 1'b0) cnt <= cnt + 1;
        else begin
            if (cnt != 0) len <= cnt;
            cnt <= 0;
        end
    end
    function automatic logic [11:0] view(input logic [11:0] v, input logic u);
        return u ? {v[11:8], 4'h0, v[11:8]} : v;
    endfunction : view
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction : xorshift
    task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic strobe(input logic s, input logic u);
        go <= 1'b1;
        sel <= s;
        up <= u;
        @(posedge clk_sys_i) go <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        #1 dq = d;
        oq = oe;
        repeat (10) @(posedge clk_sys_i);
    endtask : strobe
    task automatic summarize();
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    initial begin
        repeat (8) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i) #1 chk("busy_rst", {11'h0, busy_n}, 12'h001);
        chk("oe_idle", oe, 12'h000);
        for (int k = 0; k < 7; k++) begin
            seed = xorshift(seed);
            w = (k == 0) ? 12'h800 : (k == 1) ? 12'hFFF : (k == 2) ? 12'h000 : seed[11:0];
            strobe(1'b1, 1'b0);
            chk("oe_start", oq, 12'hFFF);
            chk("data_full", dq, prev);
            chk("busy_conv", {11'h0, busy_n}, 12'h000);
            strobe(1'b1, 1'b0);
            chk("busy_ignored", {11'h0, busy_n}, 12'h000);
            for (int t = 0; t < 400 && busy_n !== 1'b1; t++) @(posedge clk_sys_i);
            repeat (aphp_pkg::DATA_SETUP_CYC - 1) @(posedge clk_sys_i);
            #1 chk("data_setup", d, w);
            chk("conv_len", 12'(len), 12'(aphp_pkg::RESULT_W * aphp_pkg::BIT_CYCLES));
            // byte read, then two deselected strobes; a low-select read would start
            for (int m = 0; m < 3; m++) begin
                strobe(m == 0, m != 2);
                chk("data", dq & oq, (m == 0) ? view(w, 1'b1) : 12'h000);
                chk("oe", oq, (m == 0) ? 12'hFFF : 12'h000);
                chk("no_start", {11'h0, busy_n}, 12'h001);
            end
            #1 chk("held", d, w);
            prev = w;
            repeat (80) @(posedge clk_sys_i);
        end
        summarize();
    end
endmodule : aphp_port_tb
